// *** core/plsl_pkg.sv ***
package plsl_pkg;
   localparam int PLSL_PINS = 32;
   localparam logic [11:0] PLSL_OFS_OUT = 12'h504;
   localparam logic [11:0] PLSL_OFS_OUTSET = 12'h508;
   localparam logic [11:0] PLSL_OFS_OUTCLR = 12'h50C;
   localparam logic [11:0] PLSL_OFS_IN = 12'h510;
   localparam logic [11:0] PLSL_OFS_DIR = 12'h514;
   localparam logic [11:0] PLSL_OFS_DIRSET = 12'h518;
   localparam logic [11:0] PLSL_OFS_DIRCLR = 12'h51C;
   localparam logic [11:0] PLSL_OFS_CAPTURE = 12'h520;
   localparam logic [11:0] PLSL_OFS_OUTSEL = 12'h524;
   localparam logic [11:0] PLSL_OFS_SETUP_BASE = 12'h700;
   localparam logic [11:0] PLSL_OFS_SETUP_LAST = 12'h77C;
   // setup word fields
   localparam int PLSL_F_DIR = 0;
   localparam int PLSL_F_INDISC = 1;
   localparam int PLSL_F_PULL_LO = 2;
   localparam int PLSL_F_DRIVE_LO = 8;
   localparam int PLSL_F_SENSE_LO = 16;
   localparam logic [31:0] PLSL_SETUP_MASK = 32'h0003_070F;
   localparam logic [31:0] PLSL_SETUP_RESET = 32'h0000_0002;
   localparam logic [1:0] PLSL_PULL_DOWN = 2'h1;
   localparam logic [1:0] PLSL_PULL_UP = 2'h3;
   localparam logic [2:0] PLSL_DRIVE_D0S1 = 3'h4;
   localparam logic [1:0] PLSL_SENSE_HIGH = 2'h2;
   localparam logic [1:0] PLSL_SENSE_LOW = 2'h3;
   localparam logic [31:0] PLSL_CAPTURE_RESET = 32'h0000_0000;
   localparam logic PLSL_OUTSEL_MERGED = 1'b0;
   localparam logic PLSL_OUTSEL_LATCHED = 1'b1;

   typedef enum logic {PLSL_BUS_IDLE, PLSL_BUS_ACK} plsl_bus_e;
endpackage

// *** core/plsl_port.sv ***
// Behaviour
// - thirty-two pins, each with its own setup word.
// - per-pin sense field picks high or low level.
// - enabled pin at its sense level raises its own hit signal.
// - merged hit signals form the port sense output by default.
// - sensing keeps working in run and deep sleep, can wake.
// - pin already matching when enabled hits immediately.
// - rising port sense output gives a port sense event.
// - rising hit of pin n sets capture flag bit n.
// - write one clears flag unless that pin's hit is high.
// - flags stay set when hit falls; only software or a reset (power-on or low-power) clears.
// - latched sense output high while any capture flag set.
// - flags left after a clear give a fresh rising latched edge.
// - capture flags readable any time in either output mode.
// - output select picks merged hits or latched sense output.
// - input disconnect invalidates input snapshot and blinds sensing.
// - other blocks may override pin output, direction and input connect (not pulls), read input.
// - setup words retained across low power, not reset there.
// - capture flags at 0x520, bits 0..31, reset zero, W1C.
// - output select at 0x524 bit 0: 0 merged, 1 latched.
module plsl_port
   import plsl_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_lp_rst,
   input wire logic i_deep_sleep,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [11:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic [PLSL_PINS-1:0] i_pin,
   output logic [PLSL_PINS-1:0] o_pin_out,
   output logic [PLSL_PINS-1:0] o_pin_oe_n,
   output logic [PLSL_PINS-1:0] o_pull_up,
   output logic [PLSL_PINS-1:0] o_pull_down,
   input wire logic [PLSL_PINS-1:0] i_ovr_en,
   input wire logic [PLSL_PINS-1:0] i_ovr_out,
   input wire logic [PLSL_PINS-1:0] i_ovr_dir,
   input wire logic [PLSL_PINS-1:0] i_ovr_connect,
   output logic [PLSL_PINS-1:0] o_pin_in,
   output logic [PLSL_PINS-1:0] o_pin_level_hit,
   output logic o_port_sense,
   output logic o_latched_sense_out,
   output logic o_port_sense_event,
   output logic o_wake
);
   logic [31:0] setup_reg [PLSL_PINS];
   logic [31:0] out_reg;
   logic [31:0] capture_reg;
   logic [31:0] capture_next;
   logic sense_output_select_reg;
   logic clear_gap_reg;
   plsl_bus_e bus_reg;
   logic [PLSL_PINS-1:0] pin_sync;
   logic [PLSL_PINS-1:0] hit;
   logic [PLSL_PINS-1:0] hit_rise;
   logic [PLSL_PINS-1:0] dir_bits;
   logic [PLSL_PINS-1:0] connected;
   logic [PLSL_PINS-1:0] sense_en;
   logic [PLSL_PINS-1:0] sense_low;
   logic [31:0] wmask;
   logic [31:0] wbits;
   logic [31:0] rdata;
   logic wr_take;
   logic rd_take;
   logic cap_clear;
   logic port_sense_next;
   logic [PLSL_PINS-1:0] pad_val;
   logic [PLSL_PINS-1:0] pad_drv;

   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction

   function automatic logic is_setup(input logic [11:0] adr);
      is_setup = (adr >= PLSL_OFS_SETUP_BASE) && (adr <= PLSL_OFS_SETUP_LAST);
   endfunction

   function automatic logic [4:0] setup_index(input logic [11:0] adr);
      setup_index = adr[6:2];
   endfunction

   function automatic logic [1:0] pull_field(input logic [31:0] word);
      pull_field = word[PLSL_F_PULL_LO+1 -: 2];
   endfunction

   function automatic logic [1:0] sense_field(input logic [31:0] word);
      sense_field = word[PLSL_F_SENSE_LO+1 -: 2];
   endfunction

   // per-pin field extraction from the setup words
   always_comb begin
      for (int n = 0; n < PLSL_PINS; n++) begin
         dir_bits[n] = setup_reg[n][PLSL_F_DIR];
         connected[n] = ~setup_reg[n][PLSL_F_INDISC] | (i_ovr_en[n] & i_ovr_connect[n]);
         // codes below high leave sensing off
         sense_en[n] = (sense_field(setup_reg[n]) >= PLSL_SENSE_HIGH);
         sense_low[n] = (sense_field(setup_reg[n]) == PLSL_SENSE_LOW);
      end
   end

   plsl_sync u_sync (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_async(i_pin),
      .o_sync(pin_sync)
   );

   plsl_sense u_sense (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_level(pin_sync),
      .i_connected(connected),
      .i_sense_en(sense_en),
      .i_sense_low(sense_low),
      .o_hit(hit),
      .o_hit_rise(hit_rise)
   );

   // bus strobes; a request is acknowledged in the cycle after it appears
   always_comb begin
      wmask = lane_mask(i_wb_sel);
      wbits = i_wb_dat & wmask;
      wr_take = i_wb_cyc && i_wb_stb && i_wb_we && (bus_reg == PLSL_BUS_ACK);
      rd_take = i_wb_cyc && i_wb_stb && (bus_reg == PLSL_BUS_IDLE);
      cap_clear = wr_take && (i_wb_adr == PLSL_OFS_CAPTURE);
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         bus_reg <= PLSL_BUS_IDLE;
         o_wb_ack <= 1'b0;
      end else begin
         case (bus_reg)
            PLSL_BUS_IDLE: begin
               if (i_wb_cyc && i_wb_stb) begin
                  bus_reg <= PLSL_BUS_ACK;
                  o_wb_ack <= 1'b1;
               end
            end
            PLSL_BUS_ACK: begin
               bus_reg <= PLSL_BUS_IDLE;
               o_wb_ack <= 1'b0;
            end
            default: begin
               bus_reg <= PLSL_BUS_IDLE;
               o_wb_ack <= 1'b0;
            end
         endcase
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      rdata = 32'h0000_0000;
      if (is_setup(i_wb_adr)) begin
         rdata = setup_reg[setup_index(i_wb_adr)] & PLSL_SETUP_MASK;
      end else begin
         case (i_wb_adr)
            PLSL_OFS_OUT, PLSL_OFS_OUTSET, PLSL_OFS_OUTCLR: rdata = out_reg;
            PLSL_OFS_IN: rdata = pin_sync & connected;
            PLSL_OFS_DIR, PLSL_OFS_DIRSET, PLSL_OFS_DIRCLR: rdata = dir_bits;
            PLSL_OFS_CAPTURE: rdata = capture_reg;
            PLSL_OFS_OUTSEL: rdata = {31'h0000_0000, sense_output_select_reg};
            default: rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_wb_dat <= 32'h0000_0000;
      end else if (rd_take) begin
         o_wb_dat <= rdata;
      end
   end

   // setup words only see the power-on reset so they survive low power
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         for (int n = 0; n < PLSL_PINS; n++) begin
            setup_reg[n] <= PLSL_SETUP_RESET;
         end
      end else if (wr_take) begin
         if (is_setup(i_wb_adr)) begin
            setup_reg[setup_index(i_wb_adr)] <=
               ((setup_reg[setup_index(i_wb_adr)] & ~wmask) | wbits) & PLSL_SETUP_MASK;
         end else if (i_wb_adr == PLSL_OFS_DIR) begin
            for (int n = 0; n < PLSL_PINS; n++) begin
               if (wmask[n]) begin
                  setup_reg[n][PLSL_F_DIR] <= i_wb_dat[n];
               end
            end
         end else if (i_wb_adr == PLSL_OFS_DIRSET) begin
            for (int n = 0; n < PLSL_PINS; n++) begin
               if (wbits[n]) begin
                  setup_reg[n][PLSL_F_DIR] <= 1'b1;
               end
            end
         end else if (i_wb_adr == PLSL_OFS_DIRCLR) begin
            for (int n = 0; n < PLSL_PINS; n++) begin
               if (wbits[n]) begin
                  setup_reg[n][PLSL_F_DIR] <= 1'b0;
               end
            end
         end
      end
   end

   // output latch, cleared by power-on and low-power resets alike
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         out_reg <= 32'h0000_0000;
      end else if (i_lp_rst) begin
         out_reg <= 32'h0000_0000;
      end else if (wr_take) begin
         case (i_wb_adr)
            PLSL_OFS_OUT: out_reg <= (out_reg & ~wmask) | wbits;
            PLSL_OFS_OUTSET: out_reg <= out_reg | wbits;
            PLSL_OFS_OUTCLR: out_reg <= out_reg & ~wbits;
            default: out_reg <= out_reg;
         endcase
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         sense_output_select_reg <= PLSL_OUTSEL_MERGED;
      end else if (i_lp_rst) begin
         sense_output_select_reg <= PLSL_OUTSEL_MERGED;
      end else if (wr_take && (i_wb_adr == PLSL_OFS_OUTSEL) && i_wb_sel[0]) begin
         sense_output_select_reg <= i_wb_dat[0];
      end
   end

   // a new hit beats a simultaneous clear; a high hit blocks the clear
   always_comb begin
      capture_next = capture_reg;
      if (cap_clear) begin
         capture_next = capture_reg & ~(wbits & ~hit);
      end
      capture_next = capture_next | hit_rise;
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         capture_reg <= PLSL_CAPTURE_RESET;
      end else if (i_lp_rst) begin
         capture_reg <= PLSL_CAPTURE_RESET;
      end else begin
         capture_reg <= capture_next;
      end
   end

   // two low cycles after a clear so surviving flags show a new edge
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         clear_gap_reg <= 1'b0;
      end else begin
         clear_gap_reg <= cap_clear;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_latched_sense_out <= 1'b0;
      end else begin
         o_latched_sense_out <= (|capture_reg) & ~cap_clear & ~clear_gap_reg;
      end
   end

   always_comb begin
      if (sense_output_select_reg == PLSL_OUTSEL_LATCHED) begin
         port_sense_next = o_latched_sense_out;
      end else begin
         port_sense_next = |hit;
      end
   end

   // sense path has no gating by sleep state
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_port_sense <= 1'b0;
         o_port_sense_event <= 1'b0;
         o_wake <= 1'b0;
      end else begin
         o_port_sense <= port_sense_next;
         o_port_sense_event <= port_sense_next & ~o_port_sense;
         o_wake <= i_deep_sleep & port_sense_next;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_pin_level_hit <= '0;
         o_pin_in <= '0;
      end else begin
         o_pin_level_hit <= hit;
         o_pin_in <= pin_sync & connected;
      end
   end

   // wired-or drive: a low level is released instead of driven
   always_comb begin
      for (int n = 0; n < PLSL_PINS; n++) begin
         pad_val[n] = i_ovr_en[n] ? i_ovr_out[n] : out_reg[n];
         pad_drv[n] = i_ovr_en[n] ? i_ovr_dir[n] : dir_bits[n];
         if (setup_reg[n][PLSL_F_DRIVE_LO+2 -: 3] == PLSL_DRIVE_D0S1 && !pad_val[n]) begin
            pad_drv[n] = 1'b0;
         end
      end
   end

   // pad control, overridden per pin by another block
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_pin_out <= '0;
         o_pin_oe_n <= '1;
      end else begin
         o_pin_out <= pad_val;
         o_pin_oe_n <= ~pad_drv;
      end
   end

   // pulls follow the setup word only; an override leaves them alone
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_pull_up <= '0;
         o_pull_down <= '0;
      end else begin
         for (int n = 0; n < PLSL_PINS; n++) begin
            o_pull_up[n] <= (pull_field(setup_reg[n]) == PLSL_PULL_UP);
            o_pull_down[n] <= (pull_field(setup_reg[n]) == PLSL_PULL_DOWN);
         end
      end
   end
endmodule

// *** core/plsl_sense.sv ***
module plsl_sense
   import plsl_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [PLSL_PINS-1:0] i_level,
   input wire logic [PLSL_PINS-1:0] i_connected,
   input wire logic [PLSL_PINS-1:0] i_sense_en,
   input wire logic [PLSL_PINS-1:0] i_sense_low,
   output logic [PLSL_PINS-1:0] o_hit,
   output logic [PLSL_PINS-1:0] o_hit_rise
);
   logic [PLSL_PINS-1:0] match;

   // a pin already at its level hits on the first cycle sensing is on
   always_comb begin
      match = i_connected & i_sense_en & ~(i_level ^ ~i_sense_low);
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_hit <= '0;
         o_hit_rise <= '0;
      end else begin
         o_hit <= match;
         o_hit_rise <= match & ~o_hit;
      end
   end
endmodule

// *** core/plsl_sync.sv ***
module plsl_sync
   import plsl_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [PLSL_PINS-1:0] i_async,
   output logic [PLSL_PINS-1:0] o_sync
);
   logic [PLSL_PINS-1:0] stage1_reg;

   // first stage feeds only the second stage
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         stage1_reg <= '0;
         o_sync <= '0;
      end else begin
         stage1_reg <= i_async;
         o_sync <= stage1_reg;
      end
   end
endmodule

// *** dv/plsl_pin_model.sv ***
module plsl_pin_model
   import plsl_pkg::*;
(
   input wire logic i_clock,
   input wire logic [PLSL_PINS-1:0] i_ext_en,
   input wire logic [PLSL_PINS-1:0] i_ext_val,
   input wire logic [PLSL_PINS-1:0] i_pin_out,
   input wire logic [PLSL_PINS-1:0] i_pin_oe_n,
   input wire logic [PLSL_PINS-1:0] i_pull_up,
   input wire logic [PLSL_PINS-1:0] i_pull_down,
   output logic [PLSL_PINS-1:0] o_level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [PLSL_PINS-1:0] float_reg = 32'h5555_5555;
   // an undriven, unpulled pin wanders so no check leans on a settled value
   always @(posedge i_clock) begin
      float_reg <= ~float_reg;
   end
   assign o_level = (~i_pin_oe_n & i_pin_out) | (i_pin_oe_n & i_ext_en & i_ext_val)
      | (i_pin_oe_n & ~i_ext_en & (i_pull_up | (~i_pull_down & float_reg)));
endmodule

// *** dv/plsl_port_props.sv ***
module plsl_port_props
   import plsl_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_lp_rst,
   input wire logic i_deep_sleep,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [11:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic o_wb_ack,
   input wire logic [PLSL_PINS-1:0] o_pin_level_hit,
   input wire logic o_port_sense,
   input wire logic o_latched_sense_out,
   input wire logic o_port_sense_event,
   input wire logic o_wake
);
   timeunit 1ns;
   timeprecision 1ps;
   logic outsel_reg;
   logic clr_req;
   assign clr_req = i_wb_cyc && i_wb_stb && i_wb_we && i_wb_adr == PLSL_OFS_CAPTURE;
   // mode mirror lets the merged check skip the switch-over cycle
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst)
         outsel_reg <= PLSL_OUTSEL_MERGED;
      else if (i_lp_rst)
         outsel_reg <= PLSL_OUTSEL_MERGED;
      else if (o_wb_ack && i_wb_we && i_wb_sel[0] && i_wb_adr == PLSL_OFS_OUTSEL)
         outsel_reg <= i_wb_dat[0];
   end
   default clocking dc @(posedge i_clock);
   endclocking
   default disable iff (i_rst || i_lp_rst);
   a_merged_sense: assert property (
      !outsel_reg && !$past(outsel_reg) |-> o_port_sense == |o_pin_level_hit)
      else $error("port sense not merged hits");
   a_event_rise: assert property ($rose(o_port_sense) |-> o_port_sense_event)
      else $error("no event on sense rise");
   a_event_cause: assert property (o_port_sense_event |-> $rose(o_port_sense))
      else $error("event without sense rise");
   a_wake_sleep: assert property ((i_deep_sleep && o_port_sense) [*2] |-> o_wake)
      else $error("no wake in deep sleep");
   a_hit_latches: assert property (
      |(o_pin_level_hit & ~$past(o_pin_level_hit)) |-> ##[0:5] o_latched_sense_out)
      else $error("hit not latched");
   a_latch_holds: assert property (
      $fell(o_latched_sense_out) |-> $past(clr_req) || $past(clr_req, 2) || $past(clr_req, 3)
      || $past(i_lp_rst) || $past(i_lp_rst, 2)) else $error("latched output fell unasked");
   a_fresh_edge: assert property (
      clr_req && o_wb_ack ##1 (|o_pin_level_hit) |-> ##[1:5] $rose(o_latched_sense_out))
      else $error("no fresh latched edge");
   a_ack_answer: assert property ($rose(i_wb_cyc && i_wb_stb) |=> o_wb_ack)
      else $error("bus not answered");
endmodule
bind plsl_port plsl_port_props u_props (.i_clock(i_clock), .i_rst(i_rst), .i_lp_rst(i_lp_rst),
   .i_deep_sleep(i_deep_sleep), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
   .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_ack(o_wb_ack),
   .o_pin_level_hit(o_pin_level_hit), .o_port_sense(o_port_sense), .o_latched_sense_out(o_latched_sense_out),
   .o_port_sense_event(o_port_sense_event), .o_wake(o_wake));

// *** dv/test_plsl_port.sv ***
module test_plsl_port
   import plsl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   logic lp_rst = 1'b0;
   logic sleep = 1'b0;
   logic req = 1'b0;
   logic we = 1'b0;
   logic [11:0] adr = 12'h000;
   logic [31:0] wdat = 32'h0000_0000;
   logic [PLSL_PINS-1:0] ovr = 32'h0000_0000;
   logic [PLSL_PINS-1:0] ext_en = 32'hFFFF_FFFF;
   logic [PLSL_PINS-1:0] ext_val = 32'h0000_0000;
   logic [31:0] rdat;
   logic ack, psense, lsense, ev, wake;
   logic [PLSL_PINS-1:0] pin, pout, oe_n, pu, pd, pin_in, hit;
   int fails = 0;
   int samples_checked = 0;
   int events = 0;
   plsl_port dut (.i_clock(i_clock), .i_rst(i_rst), .i_lp_rst(lp_rst), .i_deep_sleep(sleep),
      .i_wb_cyc(req), .i_wb_stb(req), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
      .o_wb_dat(rdat), .o_wb_ack(ack), .i_pin(pin), .o_pin_out(pout), .o_pin_oe_n(oe_n), .o_pull_up(pu),
      .o_pull_down(pd), .i_ovr_en(ovr), .i_ovr_out(ovr), .i_ovr_dir(ovr), .i_ovr_connect(ovr),
      .o_pin_in(pin_in), .o_pin_level_hit(hit), .o_port_sense(psense), .o_latched_sense_out(lsense),
      .o_port_sense_event(ev), .o_wake(wake));
   plsl_pin_model u_pins (.i_clock(i_clock), .i_ext_en(ext_en), .i_ext_val(ext_val), .i_pin_out(pout),
      .i_pin_oe_n(oe_n), .i_pull_up(pu), .i_pull_down(pd), .o_level(pin));
   initial begin
      forever #2.5 i_clock = ~i_clock;
   end
   always @(posedge i_clock) begin
      if (ev === 1'b1)
         events++;
   end
   task automatic complete_run();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge i_clock);
      req <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge i_clock);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat;
      req <= 1'b0;
      if (ack !== 1'b1) begin
         fails++;
         complete_run();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rc(input string what, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, a, 32'h0000_0000, q);
      check(what, q, exp);
   endtask
   function automatic logic [11:0] cfg(input int n);
      return PLSL_OFS_SETUP_BASE + 12'(n * 4);
   endfunction
   function automatic logic [31:0] setup(input logic [1:0] sense, input logic disc);
      return {14'h0000, sense, 14'h0000, disc, 1'b0};
   endfunction
   // sync plus two hit registers is four edges; two spare
   task automatic settle();
      repeat (6) @(posedge i_clock);
   endtask
   task automatic drive(input int k, input logic v);
      @(posedge i_clock);
      ext_val[k] <= v;
      settle();
   endtask
   task automatic t_regs();
      rc("capture", PLSL_OFS_CAPTURE, PLSL_CAPTURE_RESET);
      rc("outsel", PLSL_OFS_OUTSEL, 32'h0000_0000);
      rc("setup31", cfg(31), PLSL_SETUP_RESET);
      wr(12'h600, 32'hFFFF_FFFF);
      rc("unmapped", 12'h600, 32'h0000_0000);
   endtask
   task automatic t_sense();
      drive(31, 1'b1);
      wr(cfg(0), setup(PLSL_SENSE_HIGH, 1'b0));
      wr(cfg(31), setup(PLSL_SENSE_LOW, 1'b0));
      settle();
      check("parked", hit, 32'h0000_0000);
      drive(0, 1'b1);
      check("hit0", hit, 32'h0000_0001);
      check("merged", psense, 1'b1);
      drive(31, 1'b0);
      check("hit both", hit, 32'h8000_0001);
      rc("flags", PLSL_OFS_CAPTURE, 32'h8000_0001);
      drive(0, 1'b0);
      drive(31, 1'b1);
      check("merged off", psense, 1'b0);
      rc("kept", PLSL_OFS_CAPTURE, 32'h8000_0001);
      wr(PLSL_OFS_CAPTURE, 32'h0000_0001);
      rc("one gone", PLSL_OFS_CAPTURE, 32'h8000_0000);
      check("latched", lsense, 1'b1);
      wr(PLSL_OFS_CAPTURE, 32'h8000_0000);
      settle();
      check("unlatched", lsense, 1'b0);
      check("events", 32'(events), 32'h0000_0001);
   endtask
   task automatic t_latch();
      drive(3, 1'b1);
      wr(cfg(3), setup(PLSL_SENSE_HIGH, 1'b0));
      settle();
      check("at once", hit[3], 1'b1);
      check("event", 32'(events), 32'h0000_0002);
      wr(PLSL_OFS_CAPTURE, 32'h0000_0008);
      @(posedge i_clock);
      check("dip", lsense, 1'b0);
      settle();
      rc("set wins", PLSL_OFS_CAPTURE, 32'h0000_0008);
      check("fresh", lsense, 1'b1);
      wr(PLSL_OFS_OUTSEL, 32'h0000_0001);
      rc("outsel", PLSL_OFS_OUTSEL, 32'h0000_0001);
      drive(3, 1'b0);
      check("latched mode", psense, 1'b1);
      rc("readable", PLSL_OFS_CAPTURE, 32'h0000_0008);
      wr(PLSL_OFS_CAPTURE, 32'h0000_0008);
      settle();
      check("latched low", psense, 1'b0);
      wr(PLSL_OFS_OUTSEL, 32'h0000_0000);
   endtask
   task automatic t_pins();
      wr(cfg(7), setup(PLSL_SENSE_HIGH, 1'b1));
      drive(7, 1'b1);
      check("blind hit", hit[7], 1'b0);
      check("blind in", pin_in[7], 1'b0);
      wr(cfg(7), 32'h0000_0000);
      settle();
      check("in", pin_in[7], 1'b1);
      @(posedge i_clock);
      ext_en[5] <= 1'b0;
      ovr[5] <= 1'b1;
      settle();
      check("ovr out", {pout[5], oe_n[5], pin_in[5]}, 3'h5);
      wr(cfg(9), 32'h0000_000E);
      settle();
      check("pulls up", {pu[9], pd[9]}, 2'h2);
      wr(cfg(9), 32'h0000_0006);
      settle();
      check("pulls down", {pu[9], pd[9]}, 2'h1);
      @(posedge i_clock);
      ovr[5] <= 1'b0;
      sleep <= 1'b1;
      drive(0, 1'b1);
      check("wake", {wake, psense}, 2'h3);
      check("wake event", 32'(events), 32'h0000_0003);
      drive(0, 1'b0);
      sleep <= 1'b0;
      lp_rst <= 1'b1;
      @(posedge i_clock);
      lp_rst <= 1'b0;
      rc("retained", cfg(31), setup(PLSL_SENSE_LOW, 1'b0));
      rc("lp flags", PLSL_OFS_CAPTURE, 32'h0000_0000);
   endtask
   initial begin
      repeat (12) @(posedge i_clock);
      i_rst <= 1'b0;
      t_regs();
      t_sense();
      t_latch();
      t_pins();
      complete_run();
   end
endmodule
